// File: hdl/ftms_defines.svh
// Offsets, field positions, reset values and timing counts of the supervisor
`ifndef FTMS_DEFINES_SVH
`define FTMS_DEFINES_SVH
`define FTMS_CLK_MHZ       100
`define FTMS_NREG          10
`define FTMS_OFF_CTRL      8'h00
`define FTMS_OFF_FLTCFG    8'h04
`define FTMS_OFF_TIMING    8'h08
`define FTMS_OFF_RETRY     8'h0c
`define FTMS_OFF_OVLIM     8'h10
`define FTMS_OFF_MGNHI     8'h14
`define FTMS_OFF_MGNLO     8'h18
`define FTMS_OFF_MGNRATE   8'h1c
`define FTMS_OFF_OTLIM     8'h20
`define FTMS_OFF_STATUS    8'h24
`define FTMS_RST_CTRL      32'h0000_0001
`define FTMS_RST_FLTCFG    32'h0000_0324
`define FTMS_RST_TIMING    32'h0008_0064
`define FTMS_RST_RETRY     32'h0000_0064
`define FTMS_RST_OVLIM     32'h0000_ffff
`define FTMS_RST_MGNRATE   32'h0000_0000
`define FTMS_RST_OTLIM     32'h0000_007d
`define FTMS_OT_HYST       8'h0f
`define FTMS_CTRL_ON       0
`define FTMS_CTRL_TRK      1
`define FTMS_CTRL_RATIO    2
`define FTMS_CTRL_SHARE    3
`define FTMS_CTRL_MGN      5:4
`define FTMS_FLT_OC        2:0
`define FTMS_FLT_OT        5:3
`define FTMS_FLT_OVLS      6
`define FTMS_FLT_RETRIES   11:8
`endif

// File: hdl/ftms_pkg.sv
// Types shared by the fault, tracking and margin supervisor
package ftms_pkg;
    typedef enum logic [6:0] {
        FTMS_IDLE  = 7'h01,
        FTMS_DLY   = 7'h02,
        FTMS_SMP   = 7'h04,
        FTMS_RAMP  = 7'h08,
        FTMS_REG   = 7'h10,
        FTMS_FWAIT = 7'h20,
        FTMS_LATCH = 7'h40
    } ftms_state_e;
    typedef enum logic [2:0] {
        FTMS_R_UNLIM = 3'h0,
        FTMS_R_COUNT = 3'h1,
        FTMS_R_DELAY = 3'h2,
        FTMS_R_CONT  = 3'h3,
        FTMS_R_IMMED = 3'h4
    } ftms_resp_e;
    typedef struct packed {
        logic hi_en;
        logic lo_en;
        logic lo_force;
    } ftms_drv_s;
    typedef logic [15:0] ftms_volt_t;
endpackage : ftms_pkg

// File: hdl/ftms_supervisor.sv
// Start-up, fault response, tracking and margin supervisor with AXI4-Lite registers
//
// How it works
// - Sample output voltage before any ramp
// - Low pre-bias: start target there, ramp up
// - Ramp ends after configured time regardless of start
// - High pre-bias: hold target at pre-bias level
// - After ramp assert good, move to target
// - Pre-bias above overvoltage limit: fault, no start
// - Overvoltage: shutdown with retries or low-side on
// - No pre-bias handling when sharing and tracking
// - Overcurrent offers five selectable responses
// - Default overcurrent: shut down, re-enable when clear
// - Thermal shutdown above limit, default 125 degrees
// - Thermal fault offers same five responses
// - Thermal restart only fifteen degrees below limit
// - Default thermal: shut down, re-enable when clear
// - Coincident tracking follows reference one to one
// - Ratiometric tracking follows half the reference
// - Tracking ignores own delay and ramp time
// - Margin pin or command raises or lowers output
// - Margins default five percent, capped plus ten
// - Margin limits, command, rate each bus writable
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "ftms_defines.svh"
module ftms_supervisor import ftms_pkg::*; (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        enable_pin,
    input  wire logic        margin_select_hi,
    input  wire logic        margin_select_lo,
    input  wire logic        oc_fault_pin,
    input  wire ftms_volt_t  nominal_setpoint,
    input  wire ftms_volt_t  vout_sample,
    input  wire ftms_volt_t  track_reference_input,
    input  wire logic [7:0]  die_temp,
    output ftms_volt_t       target_reg,
    output ftms_drv_s        drv,
    output logic             output_good
);
    // Pin synchronisers: stage 1 feeds stage 2 only
    logic [3:0]  pin_s1_reg;
    logic [3:0]  pin_s2_reg;
    logic [31:0] cfg_reg [`FTMS_NREG-1];    // Writable registers
    logic        mgn_hi_set_reg;            // Software wrote a high limit
    logic        mgn_lo_set_reg;            // Software wrote a low limit
    ftms_state_e st_reg;                    // Sequencer state
    logic [15:0] cnt_reg;                   // Delay, ramp and retry counter
    logic [15:0] persist_reg;               // Delayed-shutdown counter
    logic [15:0] rate_reg;                  // Margin slew divider
    ftms_volt_t  start_reg;                 // Sampled pre-bias
    logic        hold_reg;                  // Pre-bias above target
    logic [2:0]  src_reg;                   // Fault cause: ov, oc, ot
    logic [3:0]  left_reg;                  // Retries remaining
    // Awaited AXI halves
    logic        aw_reg;
    logic        w_reg;
    logic [7:0]  awa_reg;
    logic [31:0] wd_reg;
    logic [3:0]  ws_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_reg <= 4'h0;
            pin_s2_reg <= 4'h0;
        end else if (ce) begin
            pin_s1_reg <= {oc_fault_pin, margin_select_lo, margin_select_hi, enable_pin};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // Field views of the registers
    logic       on;
    logic       trk;
    logic       pb_ok;
    ftms_resp_e oc_resp;
    ftms_resp_e ot_resp;
    ftms_volt_t ov_lim;
    logic [7:0] ot_lim;
    logic [15:0] ramp_len;
    assign on      = pin_s2_reg[0] & cfg_reg[0][`FTMS_CTRL_ON];
    assign trk     = cfg_reg[0][`FTMS_CTRL_TRK];
    assign pb_ok   = !(trk && cfg_reg[0][`FTMS_CTRL_SHARE]);
    assign oc_resp = ftms_resp_e'(cfg_reg[1][`FTMS_FLT_OC]);
    assign ot_resp = ftms_resp_e'(cfg_reg[1][`FTMS_FLT_OT]);
    assign ov_lim  = cfg_reg[4][15:0];
    assign ot_lim  = cfg_reg[8][7:0];
    assign ramp_len = 16'h0001 << cfg_reg[2][19:16];

    // Margin goal; upper bound never passes nominal plus ten percent
    ftms_volt_t cap;
    ftms_volt_t hi_lim;
    ftms_volt_t lo_lim;
    ftms_volt_t goal;
    ftms_volt_t trk_goal;
    assign cap    = nominal_setpoint + nominal_setpoint / 16'd10;
    assign hi_lim = mgn_hi_set_reg ? cfg_reg[5][15:0]
                                   : nominal_setpoint + nominal_setpoint / 16'd20;
    assign lo_lim = mgn_lo_set_reg ? cfg_reg[6][15:0]
                                   : nominal_setpoint - nominal_setpoint / 16'd20;
    always_comb begin
        // Command overrides pin unless it says follow pin
        case (cfg_reg[0][`FTMS_CTRL_MGN])
            2'b01:   goal = nominal_setpoint;
            2'b10:   goal = lo_lim;
            2'b11:   goal = (hi_lim > cap) ? cap : hi_lim;
            default: begin
                if (pin_s2_reg[1])
                    goal = (hi_lim > cap) ? cap : hi_lim;
                else if (pin_s2_reg[2])
                    goal = lo_lim;
                else
                    goal = nominal_setpoint;
            end
        endcase
        if (goal > cap)
            goal = cap;
    end
    // Ratio of half stands in for the internal divider
    assign trk_goal = cfg_reg[0][`FTMS_CTRL_RATIO] ? (track_reference_input >> 1)
                                                   : track_reference_input;

    // Fault conditions and their clear tests
    logic ov_now;
    logic oc_now;
    logic ot_now;
    logic ot_clear;
    assign ov_now   = vout_sample > ov_lim;
    assign oc_now   = pin_s2_reg[3];
    assign ot_now   = die_temp > ot_lim;
    assign ot_clear = die_temp + `FTMS_OT_HYST < ot_lim;
    logic       flt_clear;
    ftms_resp_e cur_resp;
    always_comb begin
        // Response of the latched fault; overvoltage has three forms: unlimited, counted retries, immediate
        if (src_reg[2])
            cur_resp = ot_resp;
        else if (src_reg[1])
            cur_resp = oc_resp;
        else if (cfg_reg[1][`FTMS_FLT_OVLS])
            cur_resp = FTMS_R_UNLIM;
        else if (cfg_reg[1][`FTMS_FLT_RETRIES] != 4'h0)
            cur_resp = FTMS_R_COUNT;
        else
            cur_resp = FTMS_R_IMMED;
        flt_clear = !(src_reg[0] && ov_now) && !(src_reg[1] && oc_now)
                    && !(src_reg[2] && !ot_clear);
    end
    // Faults that shut down now versus those that are tolerated
    logic oc_stop;
    logic ot_stop;
    logic ov_stop;
    logic persist;
    assign oc_stop = oc_now && oc_resp != FTMS_R_CONT && oc_resp != FTMS_R_DELAY;
    assign ot_stop = ot_now && ot_resp != FTMS_R_CONT && ot_resp != FTMS_R_DELAY;
    assign ov_stop = ov_now && st_reg == FTMS_REG;
    assign persist = (oc_now && oc_resp == FTMS_R_DELAY) || (ot_now && ot_resp == FTMS_R_DELAY);

    // Ramp interpolation keeps total ramp time fixed for any start
    logic [31:0] prod;
    assign prod = (32'(goal - start_reg) * 32'(cnt_reg)) >> cfg_reg[2][19:16];

    // Sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg    <= FTMS_IDLE;
            cnt_reg   <= 16'h0000;
            start_reg <= 16'h0000;
            hold_reg  <= 1'b0;
            src_reg   <= 3'h0;
            left_reg  <= 4'h0;
        end else if (ce) begin
            cnt_reg <= cnt_reg + 16'h0001;
            if (!on && st_reg != FTMS_IDLE) begin
                st_reg <= FTMS_IDLE; // Enable drop ends any state, latch included
            end else begin
                case (st_reg)
                    FTMS_IDLE: begin
                        left_reg <= cfg_reg[1][`FTMS_FLT_RETRIES];
                        src_reg  <= 3'h0;
                        cnt_reg  <= 16'h0000;
                        if (on)
                            st_reg <= trk ? FTMS_SMP : FTMS_DLY;
                    end
                    FTMS_DLY: begin
                        if (cnt_reg >= cfg_reg[2][15:0])
                            st_reg <= FTMS_SMP;
                    end
                    FTMS_SMP: begin
                        // Output sampled only here, before any ramp
                        cnt_reg   <= 16'h0000;
                        start_reg <= pb_ok ? vout_sample : 16'h0000;
                        hold_reg  <= pb_ok && !trk && vout_sample >= goal;
                        if (pb_ok && ov_now) begin
                            src_reg <= 3'b001;
                            st_reg  <= FTMS_FWAIT;
                        end else begin
                            st_reg <= FTMS_RAMP;
                        end
                    end
                    FTMS_RAMP: begin
                        if (oc_stop || ot_stop) begin
                            src_reg <= {ot_stop, oc_stop, 1'b0};
                            st_reg  <= FTMS_FWAIT;
                            cnt_reg <= 16'h0000;
                        end else if (trk ? trk_goal >= goal : cnt_reg >= ramp_len)
                            st_reg <= FTMS_REG;
                    end
                    FTMS_REG: begin
                        cnt_reg <= 16'h0000;
                        if (ov_stop || oc_stop || ot_stop) begin
                            src_reg <= {ot_stop, oc_stop, ov_stop};
                            st_reg  <= FTMS_FWAIT;
                        end else if (persist && persist_reg >= cfg_reg[3][15:0])
                            st_reg <= FTMS_LATCH;
                    end
                    FTMS_FWAIT: begin
                        if (cur_resp == FTMS_R_IMMED) begin
                            if (flt_clear)
                                st_reg <= FTMS_SMP;
                        end else if (cnt_reg >= cfg_reg[3][15:0]) begin
                            cnt_reg <= 16'h0000;
                            if (cur_resp == FTMS_R_COUNT && left_reg == 4'h0)
                                st_reg <= FTMS_LATCH;
                            else begin
                                if (cur_resp == FTMS_R_COUNT)
                                    left_reg <= left_reg - 4'h1;
                                if (flt_clear)
                                    st_reg <= FTMS_SMP;
                            end
                        end
                    end
                    FTMS_LATCH: st_reg <= FTMS_LATCH; // Held until enable drops
                    default:    st_reg <= FTMS_IDLE;
                endcase
            end
        end
    end

    // Fault persistence timer for delayed shutdown
    always_ff @(posedge aclk) begin
        if (!aresetn)
            persist_reg <= 16'h0000;
        else if (ce)
            persist_reg <= (persist && st_reg == FTMS_REG) ? persist_reg + 16'h0001 : 16'h0000;
    end

    // Working target; slews to the goal once in regulation unless tracking, where it follows the reference clamped at the goal
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            target_reg <= 16'h0000;
            rate_reg   <= 16'h0000;
        end else if (ce) begin
            rate_reg <= rate_reg + 16'h0001;
            if (st_reg == FTMS_SMP)
                target_reg <= pb_ok ? vout_sample : 16'h0000;
            else if (trk && (st_reg == FTMS_RAMP || st_reg == FTMS_REG))
                target_reg <= (trk_goal > goal) ? goal : trk_goal;
            else if (st_reg == FTMS_RAMP && !hold_reg)
                target_reg <= start_reg + prod[15:0];
            else if (st_reg == FTMS_REG && rate_reg >= cfg_reg[7][15:0]) begin
                // One code per step gives a rate set independent of margin size
                rate_reg <= 16'h0000;
                if (target_reg < goal)
                    target_reg <= target_reg + 16'h0001;
                else if (target_reg > goal)
                    target_reg <= target_reg - 16'h0001;
            end
        end
    end

    // Drivers run in ramp and regulation; low side forced on in ov wait only when the low-side (OVLS) bit is set
    always_comb begin
        drv.hi_en    = st_reg == FTMS_RAMP || st_reg == FTMS_REG;
        drv.lo_en    = drv.hi_en;
        drv.lo_force = st_reg == FTMS_FWAIT && src_reg[0] && cfg_reg[1][`FTMS_FLT_OVLS];
    end
    assign output_good = st_reg == FTMS_REG && !ov_now;

    // AXI4-Lite write side; address and data may come in either order
    logic [7:0] wa;
    logic       do_wr;
    logic [3:0] widx;
    assign wa    = aw_reg ? awa_reg : s_axi_awaddr;
    assign do_wr = (aw_reg || s_axi_awvalid) && (w_reg || s_axi_wvalid) && !s_axi_bvalid;
    assign widx  = wa[5:2];
    assign s_axi_awready = !aw_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_reg && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_reg       <= 1'b0;
            w_reg        <= 1'b0;
            awa_reg      <= 8'h00;
            wd_reg       <= 32'h0000_0000;
            ws_reg       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_reg  <= 1'b1;
                awa_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_reg  <= 1'b1;
                wd_reg <= s_axi_wdata;
                ws_reg <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_reg       <= 1'b0;
                w_reg        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (widx < 4'(`FTMS_NREG - 1) && wa[1:0] == 2'b00) ? 2'b00 : 2'b10;
            end else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Register array with byte strobes; margin writes mark a user limit
    logic [31:0] wdat;
    logic [3:0]  wstb;
    assign wdat = w_reg ? wd_reg : s_axi_wdata;
    assign wstb = w_reg ? ws_reg : s_axi_wstrb;
    for (genvar g = 0; g < `FTMS_NREG - 1; g++) begin : g_cfg
        localparam logic [31:0] RSTV = (g == 0) ? `FTMS_RST_CTRL   : (g == 1) ? `FTMS_RST_FLTCFG :
                                       (g == 2) ? `FTMS_RST_TIMING : (g == 3) ? `FTMS_RST_RETRY  :
                                       (g == 4) ? `FTMS_RST_OVLIM  : (g == 7) ? `FTMS_RST_MGNRATE :
                                       (g == 8) ? `FTMS_RST_OTLIM  : 32'h0000_0000;
        always_ff @(posedge aclk) begin
            if (!aresetn)
                cfg_reg[g] <= RSTV;
            else if (ce && do_wr && widx == 4'(g) && wa[1:0] == 2'b00) begin
                for (int b = 0; b < 4; b++) begin
                    if (wstb[b])
                        cfg_reg[g][b*8 +: 8] <= wdat[b*8 +: 8];
                end
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mgn_hi_set_reg <= 1'b0;
            mgn_lo_set_reg <= 1'b0;
        end else if (ce && do_wr) begin
            if (wa == `FTMS_OFF_MGNHI)
                mgn_hi_set_reg <= 1'b1;
            if (wa == `FTMS_OFF_MGNLO)
                mgn_lo_set_reg <= 1'b1;
        end
    end

    // Read side; status word shows sequencer state and fault cause
    logic [31:0] rmux;
    logic        rok;
    always_comb begin
        rmux = 32'h0000_0000;
        rok  = 1'b1;
        if (s_axi_araddr == `FTMS_OFF_STATUS)
            rmux = {16'h0000, left_reg, 1'b0, src_reg, output_good, st_reg};
        else if (s_axi_araddr[7:2] < 6'(`FTMS_NREG - 1) && s_axi_araddr[1:0] == 2'b00)
            rmux = cfg_reg[s_axi_araddr[5:2]];
        else
            rok = 1'b0;
    end
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rmux;
                s_axi_rresp  <= rok ? 2'b00 : 2'b10;
            end else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    sequence s_smp;
        ce && st_reg == FTMS_SMP;
    endsequence
    sequence s_oc_hit;
        ce && on && st_reg == FTMS_REG && oc_now;
    endsequence
    a_good_only_reg: assert property (@(posedge aclk) disable iff (!aresetn)
        output_good |-> st_reg == FTMS_REG && drv.hi_en) else $error("good outside reg");
    a_prebias_ov_fault: assert property (@(posedge aclk) disable iff (!aresetn)
        s_smp and (on && pb_ok && ov_now) |=> st_reg == FTMS_FWAIT && !drv.hi_en)
        else $error("ov prebias started");
    a_prebias_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_smp and (on && pb_ok && !ov_now) |=> target_reg == $past(vout_sample))
        else $error("prebias target wrong");
    a_ramp_time: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && on && !trk && st_reg == FTMS_RAMP |->
        cnt_reg <= ramp_len) else $error("ramp long");
    a_oc_immed_off: assert property (@(posedge aclk) disable iff (!aresetn)
        s_oc_hit and (oc_resp == FTMS_R_IMMED) |=> st_reg == FTMS_FWAIT ##0 !drv.hi_en)
        else $error("oc no shutdown");
    a_oc_continue: assert property (@(posedge aclk) disable iff (!aresetn)
        s_oc_hit and (oc_resp == FTMS_R_CONT && !ot_now && !ov_now) |=> st_reg == FTMS_REG)
        else $error("oc continue stopped");
    a_ot_restart: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && st_reg == FTMS_FWAIT && src_reg == 3'b100 ##1 st_reg == FTMS_SMP |->
        $past(ot_clear)) else $error("ot restart hot");
    a_retry_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && st_reg == FTMS_FWAIT ##1 st_reg == FTMS_LATCH |-> $past(left_reg) == 4'h0)
        else $error("latched early");
    a_margin_cap: assert property (@(posedge aclk) disable iff (!aresetn)
        goal <= cap) else $error("margin above cap");
    a_trk_skip_dly: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && on && trk && st_reg == FTMS_IDLE |=> st_reg == FTMS_SMP)
        else $error("tracking used delay");
    a_open_nominal: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_reg[0][5:4] == 2'b00 && !pin_s2_reg[1] && !pin_s2_reg[2] |->
        goal == nominal_setpoint || nominal_setpoint > cap) else $error("open not nominal");
endmodule : ftms_supervisor

// File: testbench/ftms_plant.sv
// Output stage model that closes the loop around the supervisor
`timescale 1ns/1ps
module ftms_plant import ftms_pkg::*; (
    input  wire logic       aclk,
    input  wire ftms_drv_s  drv,
    input  wire ftms_volt_t target_reg,
    input  wire ftms_volt_t pre_bias,
    output ftms_volt_t      vout_sample
);
    // Driven output tracks the target; undriven output rests at the external pre-bias
    always_ff @(posedge aclk) begin
        vout_sample <= drv.hi_en ? target_reg : pre_bias;
    end
endmodule : ftms_plant

// File: testbench/tb_fault_track_margin_supervisor.sv
// Self-checking bench: start-up, faults, tracking and margins
`timescale 1ns/1ps
module tb_fault_track_margin_supervisor import ftms_pkg::*; ;
    logic aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, enable_pin, margin_select_hi, margin_select_lo, oc_fault_pin;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, output_good;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, die_temp;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    ftms_volt_t  nominal_setpoint, vout_sample, track_reference_input, target_reg, pre_bias;
    ftms_drv_s   drv;
    int          err_count, cmp_count, n0, n1;
    ftms_volt_t  margin_select [3] = '{16'h10cc, 16'h0f34, 16'h1000};   // High, low, open
    ftms_supervisor u_dut (.*);
    ftms_plant u_plant (.aclk, .drv, .target_reg, .pre_bias, .vout_sample);
    task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : cmp
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    // One bus transfer; valids dropped only at the edge that takes them
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       m = '1, input logic [1:0] r = 2'h0);
        logic ta, tw, tr, ans;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        for (int i = 0; i < 99; i++) begin
            @(negedge aclk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tr = s_axi_arvalid & s_axi_arready;
            ans = w ? s_axi_bvalid : s_axi_rvalid;
            if (ans === 1'b1) break;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tr) s_axi_arvalid <= 1'b0;
        end
        cmp(ans, 1'b1);
        if (ans !== 1'b1) print_verdict();
        cmp(w ? s_axi_bresp : s_axi_rresp, r);
        if (!w) cmp(s_axi_rdata & m, d & m);
        @(posedge aclk);
        {s_axi_bready, s_axi_rready} <= 2'b00;
    endtask : bus
    // Pins change together at a rising edge; one enable source for the group
    task automatic set(input logic e, h, l, o, input logic [7:0] t = 8'h19,
                       input ftms_volt_t p = '0, k = '0);
        @(posedge aclk);
        {enable_pin, margin_select_hi, margin_select_lo, oc_fault_pin} <= {e, h, l, o};
        {die_temp, pre_bias, track_reference_input} <= {t, p, k};
    endtask : set
    task automatic hold(input int n);
        repeat (n) @(negedge aclk);
    endtask : hold
    // Bounded wait on the good flag; n counts cycles taken
    task automatic wait_good(input logic v, output int n);
        for (n = 0; n < 3000; n++) begin
            @(negedge aclk);
            if (output_good === v) break;
        end
        cmp(output_good, v);
        if (output_good !== v) print_verdict();
    endtask : wait_good
    task automatic restart(input ftms_volt_t p, output int n);
        set(0, 0, 0, 0, 8'h19, p);
        wait_good(0, n);
        set(1, 0, 0, 0, 8'h19, p);
        wait_good(1, n);
    endtask : restart
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, err_count, cmp_count} = '0;
        {enable_pin, margin_select_hi, margin_select_lo, oc_fault_pin} = '0;
        {track_reference_input, pre_bias, ce, s_axi_wstrb, die_temp} = {32'h0, 5'h1f, 8'h19};
        nominal_setpoint = 16'h1000;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        bus(0, 8'h04, 32'h324);
        bus(0, 8'h20, 32'h7d);
        bus(0, 8'h30, 32'h0, '1, 2'h2);
        bus(1, 8'h24, 32'h0, '1, 2'h2);
        bus(1, 8'h08, 32'h0002_0004);
        restart(16'h0, n0);
        cmp(target_reg, 16'h1000);
        restart(16'h0800, n1);
        cmp(n1, n0);
        restart(16'h1100, n1);
        cmp(n1, n0);
        cmp(target_reg, 16'h1100);
        hold(600);
        cmp(target_reg, 16'h1000);
        bus(1, 8'h10, 32'h1800);
        set(0, 0, 0, 0, 8'h19, 16'h2000);
        bus(1, 8'h04, 32'h364);
        set(1, 0, 0, 0, 8'h19, 16'h2000);
        hold(60);
        cmp({output_good, drv.hi_en, drv.lo_force}, 3'h1);
        bus(1, 8'h10, 32'hffff);
        restart(16'h0, n1);
        set(1, 0, 0, 1);
        wait_good(0, n1);
        cmp(drv.hi_en, 1'b0);
        set(1, 0, 0, 0);
        wait_good(1, n1);
        set(1, 0, 0, 0, 8'd126);
        wait_good(0, n1);
        set(1, 0, 0, 0, 8'd115);
        hold(300);
        cmp(output_good, 1'b0);
        set(1, 0, 0, 0, 8'd100);
        wait_good(1, n1);
        for (int i = 0; i < 3; i++) begin
            set(1, i == 0, i == 1, 0);
            hold(600);
            cmp(target_reg, margin_select[i]);
        end
        bus(1, 8'h00, 32'h31);
        bus(1, 8'h14, 32'h2000);
        hold(600);
        cmp(target_reg, 16'h1199);
        set(0, 0, 0, 0, 8'h19, 16'h0, 16'h0400);
        bus(1, 8'h00, 32'h3);
        set(1, 0, 0, 0, 8'h19, 16'h0, 16'h0400);
        hold(600);
        cmp(target_reg, 16'h0400);
        bus(1, 8'h00, 32'h7);
        hold(600);
        cmp(target_reg, 16'h0200);
        print_verdict();
    end
endmodule : tb_fault_track_margin_supervisor
